//--- adst_defs.svh
`ifndef ADST_DEFS_SVH
`define ADST_DEFS_SVH
// Register byte addresses
`define ADST_OFS_IBUF    32'h40081400
`define ADST_OFS_SEQ     32'h40086088
`define ADST_OFS_SEQCFG  32'h4008608C
`define ADST_OFS_CMP     32'h40086098
`define ADST_OFS_CNV     32'h4008609C
`define ADST_OFS_TEMP    32'h40087830
`define ADST_OFS_REF     32'h40087834
// Upper address page of the narrow registers
`define ADST_NARROW_PAGE 20'h40081
// Link latency in cycles for word and narrow registers
`define ADST_LAT_WORD    4'h8
`define ADST_LAT_BYTE    4'h5
// Reset values, internal-channel timing preset, single-ended code and halt delay
`define ADST_RST_IBUF    16'h000F
`define ADST_RST_SEQCFG  32'h0008C631
`define ADST_RST_CNV     32'h000A0014
`define ADST_AUTO_CNV    32'h007D00FA
`define ADST_SINGLE_END  5'h11
`define ADST_HALT_DELAY  8'hFF
// Positive selector codes
`define ADST_CH_TEMP     5'h16
`define ADST_CH_IOVDD    5'h19
`define ADST_CH_AVDD     5'h1A
`define ADST_CH_CMP      5'h04
// Field positions
`define ADST_RESTART_BIT 31
`define ADST_ENABLE_BIT  30
`define ADST_MASK_MSB    28
`define ADST_DELAY_MSB   27
`define ADST_DELAY_LSB   20
`define ADST_NEG6_LSB    15
`define ADST_NEG4_LSB    10
`define ADST_NEG2_LSB    5
`define ADST_NEG0_LSB    0
`define ADST_THR_MSB     17
`define ADST_THR_LSB     2
`define ADST_DIR_BIT     1
`define ADST_CEN_BIT     0
`define ADST_ACQ_MSB     25
`define ADST_ACQ_LSB     16
`define ADST_DIV_MSB     9
// Reference tick: clock and reference rates in MHz
`define ADST_CLK_MHZ     9'h0FA
`define ADST_REF_MHZ     9'h014
`endif

//--- adst_pkg.sv
package adst_pkg;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ADST_IDLE = 3'b001,
    ADST_RUN  = 3'b010,
    ADST_GAP  = 3'b100
  } adst_state_type;
  // Register access request over the die link
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } adst_reg_req_type;
  // Conversion request toward the converter core
  typedef struct packed {
    logic       start;
    logic [4:0] pos;
    logic [4:0] neg;
  } adst_conv_type;
endpackage : adst_pkg

//--- adst_seq_ctrl.sv
// Functional notes
// - Restart bit jumps to first included channel
// - Enable bit starts automatic channel sequencing
// - 29-bit mask selects channels in sequence
// - Delay field pauses 0-254 units between sequences
// - Delay 255 halts after one sequence
// - Negative input fields for AIN0/2/4/6, 0x11 single
// - Channel 4 compared to threshold when enabled
// - Direction bit picks below or above test
// - Conversion rate is 20 MHz over divider
// - Acquisition time is count over 20 MHz
// - Internal single conversions load 80 kSPS timing while sequencer idle
// - Sequencer never alters the timing register
// - Link access takes 8 or 5 cycles
// - Codes 0x16/0x19/0x1A are internal channels
`timescale 1ns/1ps
`include "adst_defs.svh"

module adst_seq_ctrl (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire adst_pkg::adst_reg_req_type reg_in,
  output logic                           reg_busy,
  output logic                           reg_ack,
  output logic [31:0]                    reg_rdata,
  input  wire logic                      single_start,
  input  wire logic [4:0]                single_pos,
  output adst_pkg::adst_conv_type        conv_out,
  output logic                           conv_acquire,
  output logic [9:0]                     conv_rate_divider,
  output logic [9:0]                     conv_acquisition_count,
  input  wire logic                      conv_done,
  input  wire logic [15:0]               conv_data,
  output logic                           seq_active,
  output logic                           compare_flag,
  output logic [15:0]                    ibuf_ctrl,
  output logic [7:0]                     temp_ctrl,
  output logic [7:0]                     ref_ctrl
);
  import adst_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Register file and die link
  logic [28:0] seq_mask;          // Channel inclusion mask
  logic [31:0] seq_cfg;           // Delay and negative inputs
  logic [17:0] cmp_cfg;           // Threshold, direction, enable
  logic [31:0] cnv_timing;        // Acquisition and divider
  logic [3:0]  link_cnt;          // Cycles left in link access
  logic        link_we;           // Latched access kind
  logic [31:0] link_addr;         // Latched address
  logic [31:0] link_wdata;        // Latched write data
  logic        seq_enable_pulse;  // Enable bit written
  logic        seq_restart_pulse; // Restart bit written
  logic [28:0] next_seq_mask;
  logic [31:0] next_seq_cfg;
  logic [17:0] next_cmp_cfg;
  logic [31:0] next_cnv_timing;
  logic [15:0] next_ibuf_ctrl;
  logic [7:0]  next_temp_ctrl;
  logic [7:0]  next_ref_ctrl;
  logic [3:0]  next_link_cnt;
  logic        next_link_we;
  logic [31:0] next_link_addr;
  logic [31:0] next_link_wdata;
  logic        next_reg_ack;
  logic [31:0] next_reg_rdata;
  logic        next_enable_pulse;
  logic        next_restart_pulse;
  logic        taken;             // Request accepted this cycle
  logic        commit;            // Access completes this cycle
  logic        cmp_hit;           // Comparator condition true
  logic        auto_load;         // Internal single conversion

  assign reg_busy = (link_cnt != 4'h0);
  assign taken    = reg_in.req && !reg_busy;
  assign commit   = (link_cnt == 4'h1);
  // Timing preset only for single conversions outside sequencing
  assign auto_load = single_start && !seq_active &&
    (single_pos == `ADST_CH_TEMP || single_pos == `ADST_CH_IOVDD ||
     single_pos == `ADST_CH_AVDD);

  // Next values of registers and link state
  always_comb begin
    next_seq_mask      = seq_mask;
    next_seq_cfg       = seq_cfg;
    next_cmp_cfg       = cmp_cfg;
    next_cnv_timing    = cnv_timing;
    next_ibuf_ctrl     = ibuf_ctrl;
    next_temp_ctrl     = temp_ctrl;
    next_ref_ctrl      = ref_ctrl;
    next_link_we       = link_we;
    next_link_addr     = link_addr;
    next_link_wdata    = link_wdata;
    next_link_cnt      = link_cnt;
    next_reg_ack       = 1'b0;
    next_reg_rdata     = reg_rdata;
    next_enable_pulse  = 1'b0;
    next_restart_pulse = 1'b0;
    if (taken) begin
      // Latency depends on the register class
      next_link_we    = reg_in.we;
      next_link_addr  = reg_in.addr;
      next_link_wdata = reg_in.wdata;
      if (reg_in.addr[31:12] == `ADST_NARROW_PAGE) begin
        next_link_cnt = `ADST_LAT_BYTE;
      end else begin
        next_link_cnt = `ADST_LAT_WORD;
      end
    end else if (reg_busy) begin
      next_link_cnt = link_cnt - 4'h1;
    end
    if (auto_load) begin
      // Preset to 80 kSPS
      next_cnv_timing = `ADST_AUTO_CNV;
    end
    if (commit) begin
      next_reg_ack   = 1'b1;
      next_reg_rdata = 32'h0;
      case (link_addr)
        `ADST_OFS_SEQ: begin
          // Control bits read as zero, only mask reads back
          next_reg_rdata = {3'h0, seq_mask};
          if (link_we) begin
            next_seq_mask      = link_wdata[`ADST_MASK_MSB:0];
            next_enable_pulse  = link_wdata[`ADST_ENABLE_BIT];
            next_restart_pulse = link_wdata[`ADST_RESTART_BIT];
          end
        end
        `ADST_OFS_SEQCFG: begin
          next_reg_rdata = {4'h0, seq_cfg[27:0]};
          if (link_we) begin
            next_seq_cfg = {4'h0, link_wdata[27:0]};
          end
        end
        `ADST_OFS_CMP: begin
          next_reg_rdata = {14'h0, cmp_cfg};
          if (link_we) begin
            next_cmp_cfg = link_wdata[17:0];
          end
        end
        `ADST_OFS_CNV: begin
          // Shows preset value after an internal single conversion
          next_reg_rdata = cnv_timing;
          if (link_we) begin
            next_cnv_timing = link_wdata;
          end
        end
        `ADST_OFS_IBUF: begin
          next_reg_rdata = {16'h0, ibuf_ctrl};
          if (link_we) begin
            next_ibuf_ctrl = link_wdata[15:0];
          end
        end
        `ADST_OFS_TEMP: begin
          next_reg_rdata = {24'h0, temp_ctrl};
          if (link_we) begin
            next_temp_ctrl = link_wdata[7:0];
          end
        end
        `ADST_OFS_REF: begin
          next_reg_rdata = {24'h0, ref_ctrl};
          if (link_we) begin
            next_ref_ctrl = link_wdata[7:0];
          end
        end
        default: begin
          // Unmapped address reads zero, writes dropped
          next_reg_rdata = 32'h0;
        end
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      seq_mask          <= 29'h0;
      seq_cfg           <= `ADST_RST_SEQCFG;
      cmp_cfg           <= 18'h0;
      cnv_timing        <= `ADST_RST_CNV;
      ibuf_ctrl         <= `ADST_RST_IBUF;
      temp_ctrl         <= 8'h0;
      ref_ctrl          <= 8'h0;
      link_cnt          <= 4'h0;
      link_we           <= 1'b0;
      link_addr         <= 32'h0;
      link_wdata        <= 32'h0;
      reg_ack           <= 1'b0;
      reg_rdata         <= 32'h0;
      seq_enable_pulse  <= 1'b0;
      seq_restart_pulse <= 1'b0;
    end else begin
      seq_mask          <= next_seq_mask;
      seq_cfg           <= next_seq_cfg;
      cmp_cfg           <= next_cmp_cfg;
      cnv_timing        <= next_cnv_timing;
      ibuf_ctrl         <= next_ibuf_ctrl;
      temp_ctrl         <= next_temp_ctrl;
      ref_ctrl          <= next_ref_ctrl;
      link_cnt          <= next_link_cnt;
      link_we           <= next_link_we;
      link_addr         <= next_link_addr;
      link_wdata        <= next_link_wdata;
      reg_ack           <= next_reg_ack;
      reg_rdata         <= next_reg_rdata;
      seq_enable_pulse  <= next_enable_pulse;
      seq_restart_pulse <= next_restart_pulse;
    end
  end

  assign conv_rate_divider      = cnv_timing[`ADST_DIV_MSB:0];
  assign conv_acquisition_count = cnv_timing[`ADST_ACQ_MSB:`ADST_ACQ_LSB];

  ////////////////////////////////////////////////////////////////
  // Sequencer
  adst_state_type state, next_state;
  logic [8:0] ref_acc, next_ref_acc; // Fractional 20 MHz generator
  logic       ref_tick;              // One 20 MHz reference period
  logic [9:0] per_cnt, next_per_cnt; // Ticks into conversion period
  logic       period_end;            // Conversion slot boundary
  logic [9:0] acq_cnt, next_acq_cnt; // Acquisition ticks remaining
  logic [7:0] gap_cnt, next_gap_cnt; // Delay units remaining
  logic [4:0] cur_ch, next_cur_ch;   // Channel of the next slot
  logic [4:0] last_ch, next_last_ch; // Channel last converted
  logic       next_acquire;
  logic       next_flag;
  adst_conv_type next_conv;
  logic       first_ok, above_ok;    // Search results valid
  logic [4:0] first_ch, above_ch;    // Search results
  logic [5:0] first_idx, above_idx;  // Raw search results, 0x3F when none

  // Lowest included channel at or above a start index
  function automatic logic [5:0] find_ch(input logic [28:0] mask,
                                         input logic [5:0]  from);
    logic [5:0] res;
    res = 6'h3F;
    for (int i = 28; i >= 0; i--) begin
      if (mask[i] && (6'(i) >= from)) begin
        res = 6'(i);
      end
    end
    return res;
  endfunction : find_ch

  // Ascending search from zero and from above the current slot
  always_comb begin
    {first_ok, first_ch} = {1'b0, 5'h0};
    {above_ok, above_ch} = {1'b0, 5'h0};
    first_idx = find_ch(seq_mask, 6'h0);
    above_idx = find_ch(seq_mask, {1'b0, cur_ch} + 6'h1);
    if (first_idx != 6'h3F) begin
      first_ok = 1'b1;
      first_ch = first_idx[4:0];
    end
    if (above_idx != 6'h3F) begin
      above_ok = 1'b1;
      above_ch = above_idx[4:0];
    end
  end

  // Reference tick: accumulate 20 per cycle, wrap at 250
  assign ref_tick   = (ref_acc + `ADST_REF_MHZ) >= `ADST_CLK_MHZ;
  assign period_end = ref_tick &&
    ((per_cnt + 10'h1) >= conv_rate_divider);
  assign cmp_hit = cmp_cfg[`ADST_CEN_BIT] && conv_done &&
    (last_ch == `ADST_CH_CMP) &&
    (cmp_cfg[`ADST_DIR_BIT] ?
      (cmp_cfg[`ADST_THR_MSB:`ADST_THR_LSB] > conv_data) :
      (cmp_cfg[`ADST_THR_MSB:`ADST_THR_LSB] < conv_data));

  // Next sequencer values
  always_comb begin
    next_state   = state;
    next_cur_ch  = cur_ch;
    next_last_ch = last_ch;
    next_gap_cnt = gap_cnt;
    next_conv    = '{start: 1'b0, pos: conv_out.pos, neg: conv_out.neg};
    next_ref_acc = ref_tick ? 9'(ref_acc + `ADST_REF_MHZ - `ADST_CLK_MHZ)
                            : 9'(ref_acc + `ADST_REF_MHZ);
    next_per_cnt = period_end ? 10'h0 : (ref_tick ? per_cnt + 10'h1 : per_cnt);
    next_acq_cnt = (ref_tick && acq_cnt != 10'h0) ? acq_cnt - 10'h1 : acq_cnt;
    // Set wins over the clear by a config write
    next_flag    = cmp_hit ||
      (compare_flag && !(commit && link_we && link_addr == `ADST_OFS_CMP));
    case (state)
      ADST_IDLE: begin
        if (seq_enable_pulse && first_ok) begin
          next_state  = ADST_RUN;
          next_cur_ch = first_ch;
        end
      end
      ADST_RUN: begin
        if (seq_restart_pulse) begin
          next_cur_ch = first_ch;
        end else if (!first_ok) begin
          next_state = ADST_IDLE;
        end else if (period_end) begin
          // Issue slot for the current channel
          next_conv.start = 1'b1;
          next_conv.pos   = cur_ch;
          next_last_ch    = cur_ch;
          next_acq_cnt    = conv_acquisition_count;
          case (cur_ch)
            5'h00: next_conv.neg = seq_cfg[`ADST_NEG0_LSB +: 5];
            5'h02: next_conv.neg = seq_cfg[`ADST_NEG2_LSB +: 5];
            5'h04: next_conv.neg = seq_cfg[`ADST_NEG4_LSB +: 5];
            5'h06: next_conv.neg = seq_cfg[`ADST_NEG6_LSB +: 5];
            default: next_conv.neg = `ADST_SINGLE_END;
          endcase
          if (above_ok) begin
            next_cur_ch = above_ch;
          end else if (seq_cfg[`ADST_DELAY_MSB:`ADST_DELAY_LSB] ==
                       `ADST_HALT_DELAY) begin
            next_state = ADST_IDLE;
          end else begin
            next_state   = ADST_GAP;
            next_gap_cnt = seq_cfg[`ADST_DELAY_MSB:`ADST_DELAY_LSB];
          end
        end
      end
      ADST_GAP: begin
        if (seq_restart_pulse || (period_end && gap_cnt == 8'h0)) begin
          next_state  = first_ok ? ADST_RUN : ADST_IDLE;
          next_cur_ch = first_ch;
        end else if (period_end) begin
          next_gap_cnt = gap_cnt - 8'h1;
        end
      end
      default: begin
        next_state = ADST_IDLE;
      end
    endcase
    next_acquire = (next_acq_cnt != 10'h0);
  end

  // Sequencer storage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state        <= ADST_IDLE;
      ref_acc      <= 9'h0;
      per_cnt      <= 10'h0;
      acq_cnt      <= 10'h0;
      gap_cnt      <= 8'h0;
      cur_ch       <= 5'h0;
      last_ch      <= 5'h0;
      conv_out     <= '{start: 1'b0, pos: 5'h0, neg: `ADST_SINGLE_END};
      conv_acquire <= 1'b0;
      compare_flag <= 1'b0;
    end else begin
      state        <= next_state;
      ref_acc      <= next_ref_acc;
      per_cnt      <= next_per_cnt;
      acq_cnt      <= next_acq_cnt;
      gap_cnt      <= next_gap_cnt;
      cur_ch       <= next_cur_ch;
      last_ch      <= next_last_ch;
      conv_out     <= next_conv;
      conv_acquire <= next_acquire;
      compare_flag <= next_flag;
    end
  end

  assign seq_active = (state != ADST_IDLE);

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_link_word_lat: assert property (
    taken && reg_in.addr[31:12] != `ADST_NARROW_PAGE |=> !reg_ack [*8] ##1 reg_ack)
    else $error("word access latency wrong");
  a_link_byte_lat: assert property (
    taken && reg_in.addr[31:12] == `ADST_NARROW_PAGE |=> !reg_ack [*5] ##1 reg_ack)
    else $error("narrow access latency wrong");
  a_restart_first: assert property (
    seq_restart_pulse && state == ADST_RUN |=> cur_ch == $past(first_ch))
    else $error("restart did not return to first channel");
  a_halt_after_one: assert property (
    state == ADST_RUN && period_end && !above_ok && !seq_restart_pulse &&
    seq_cfg[27:20] == 8'hFF |=> state == ADST_IDLE)
    else $error("delay 255 did not halt");
  a_auto_preset: assert property (
    auto_load && !commit |=> cnv_timing == 32'h007D00FA)
    else $error("internal channel preset missing");
  a_seq_keeps_cnv: assert property (
    seq_active && !commit |=> $stable(cnv_timing))
    else $error("timing changed during sequence");
  a_neg_single: assert property (
    conv_out.start && conv_out.pos != 5'h0 && conv_out.pos != 5'h2 &&
    conv_out.pos != 5'h4 && conv_out.pos != 5'h6 |-> conv_out.neg == 5'h11)
    else $error("odd channel not single ended");
  a_cmp_flag_set: assert property (
    cmp_hit |=> compare_flag)
    else $error("compare flag not set");
  a_cmp_disabled: assert property (
    !cmp_cfg[0] && !compare_flag |=> !compare_flag)
    else $error("flag set while comparator off");
  a_ascending: assert property (
    state == ADST_RUN && period_end && above_ok && !seq_restart_pulse |=>
    conv_out.start && cur_ch > $past(cur_ch))
    else $error("channels not ascending");
endmodule : adst_seq_ctrl

//--- adst_core_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Converter core stand-in: answers each start after a fixed latency
module adst_core_model (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire adst_pkg::adst_conv_type conv_in,
  input  wire logic [15:0]             result_value,
  output logic                         conv_done,
  output logic [15:0]                  conv_data
);
  import adst_pkg::*;
  logic [2:0] busy_count;  // Cycles left in the conversion
  // Result shows only in the done cycle; otherwise the bus keeps changing
  always @(posedge clk_sys) begin
    if (reset) begin
      busy_count <= 3'h0;
      conv_done  <= 1'b0;
      conv_data  <= 16'hA5A5;
    end else begin
      conv_done <= (busy_count == 3'h1);
      conv_data <= (busy_count == 3'h1) ? result_value : ~conv_data;
      if (conv_in.start) begin
        busy_count <= 3'h6;
      end else if (busy_count != 3'h0) begin
        busy_count <= busy_count - 3'h1;
      end
    end
  end
endmodule : adst_core_model

//--- adc_sequencer_timing_control_test.sv
`timescale 1ns/1ps
`include "adst_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
////////////////////////////////////////////////////////////////////////////////
module adc_sequencer_timing_control_test;
  import adst_pkg::*;
  logic             clk_sys = 1'b0;   // 250 MHz system clock
  logic             reset = 1'b1;     // Synchronous reset
  adst_reg_req_type reg_in = '0;      // Register request
  logic             reg_busy, reg_ack;
  logic [31:0]      reg_rdata;
  logic             single_start = 1'b0;
  logic [4:0]       single_pos = 5'h00;
  adst_conv_type    conv_out;
  logic             conv_acquire, conv_done, seq_active, compare_flag;
  logic [9:0]       conv_rate_divider, conv_acquisition_count;
  logic [15:0]      conv_data, result_value = 16'h0000;
  logic [15:0]      ibuf_ctrl;
  logic [7:0]       temp_ctrl, ref_ctrl;
  int               bad_count = 0;
  int               comparisons = 0;
  logic [9:0]       sq[$];            // Observed starts {pos, neg}
  time              st[$];            // Times of those starts
  logic [31:0]      rd;
  logic [9:0]       sv;
  time              t0, t1;
  logic [31:0]      addrs[8] = '{`ADST_OFS_SEQ, `ADST_OFS_SEQCFG, `ADST_OFS_CMP,
    `ADST_OFS_CNV, `ADST_OFS_IBUF, `ADST_OFS_TEMP, `ADST_OFS_REF, 32'h40086094};
  logic [31:0]      rsts[8] = '{32'h0, `ADST_RST_SEQCFG, 32'h0, `ADST_RST_CNV,
    32'h0000000F, 32'h0, 32'h0, 32'h0};
  logic [9:0]       seq_b[5] = '{10'h001, 10'h043, 10'h085, 10'h0C7, 10'h2D1};
  logic [31:0]      cmp_c[5] = '{32'h4001, 32'h4003, 32'h4003, 32'h4000, 32'h4001};
  logic [15:0]      dat_c[5] = '{16'h2000, 16'h2000, 16'h0800, 16'h0800, 16'h1000};
  logic             flg_c[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [4:0]       auto_c[4] = '{`ADST_CH_TEMP, `ADST_CH_IOVDD, `ADST_CH_AVDD, 5'h05};

  always #2 clk_sys = ~clk_sys;

  adst_seq_ctrl u_dut (.clk_sys(clk_sys), .reset(reset), .reg_in(reg_in),
    .reg_busy(reg_busy), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
    .single_start(single_start), .single_pos(single_pos), .conv_out(conv_out),
    .conv_acquire(conv_acquire), .conv_rate_divider(conv_rate_divider),
    .conv_acquisition_count(conv_acquisition_count), .conv_done(conv_done),
    .conv_data(conv_data), .seq_active(seq_active), .compare_flag(compare_flag),
    .ibuf_ctrl(ibuf_ctrl), .temp_ctrl(temp_ctrl), .ref_ctrl(ref_ctrl));

  adst_core_model u_core (.clk_sys(clk_sys), .reset(reset), .conv_in(conv_out),
    .result_value(result_value), .conv_done(conv_done), .conv_data(conv_data));

  // Record every conversion start away from the launching edge
  always @(negedge clk_sys) begin
    if (conv_out.start === 1'b1) begin
      sq.push_back({conv_out.pos, conv_out.neg});
      st.push_back($time);
    end
  end

  // Counts, verdict, end of run
  task automatic close_out();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // One link access; request dropped after the take edge
  task automatic xfer(input logic we, input logic [31:0] addr, wd);
    int lat;
    @(posedge clk_sys);
    reg_in <= '{1'b1, we, addr, wd};
    @(posedge clk_sys);
    reg_in.req <= 1'b0;
    lat = 0;
    while (lat < 40 && reg_ack !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      lat++;
      if (lat == 1) `CHK(reg_busy, 1'b1)
    end
    if (lat >= 40) begin
      bad_count++;
      close_out();
    end
    rd = reg_rdata;
    `CHK(lat, (addr[31:12] == `ADST_NARROW_PAGE) ? 5 : 8)
  endtask : xfer

  // Next recorded start, bounded wait
  task automatic get_start();
    int n;
    n = 0;
    while (sq.size() == 0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 4000) begin
      bad_count++;
      close_out();
    end
    sv = sq.pop_front();
    t1 = st.pop_front();
  endtask : get_start

  // Wait for the sequencer to fall idle, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    while (seq_active !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 4000) begin
      bad_count++;
      close_out();
    end
    `CHK(seq_active, 1'b0)
    repeat (4) @(posedge clk_sys);
    sq.delete();
    st.delete();
  endtask : wait_idle

  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset values, unmapped read, timing outputs
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, addrs[i], 32'h0);
      `CHK(rd, rsts[i])
    end
    `CHK(conv_rate_divider, 10'h014)
    `CHK(conv_acquisition_count, 10'h00A)
    `CHK({ibuf_ctrl, temp_ctrl, ref_ctrl}, 32'h000F0000)
    xfer(1'b1, `ADST_OFS_REF, 32'h00000005);
    `CHK(ref_ctrl, 8'h05)
    // One halting sequence over AIN0/2/4/6 and an internal channel
    xfer(1'b1, `ADST_OFS_SEQCFG, 32'h0FF39461);
    xfer(1'b0, `ADST_OFS_SEQCFG, 32'h0);
    `CHK(rd, 32'h0FF39461)
    xfer(1'b1, `ADST_OFS_SEQ, 32'h40400055);
    xfer(1'b0, `ADST_OFS_SEQ, 32'h0);
    `CHK(rd, 32'h00400055)
    for (int i = 0; i < 5; i++) begin
      get_start();
      `CHK(sv, seq_b[i])
    end
    wait_idle();
    repeat (600) @(posedge clk_sys);
    `CHK(sq.size(), 0)
    xfer(1'b0, `ADST_OFS_CNV, 32'h0);
    `CHK(rd, `ADST_RST_CNV)
    // Comparator on channel 4, one sequence per case
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, `ADST_OFS_CMP, cmp_c[i]);
      result_value <= dat_c[i];
      xfer(1'b1, `ADST_OFS_SEQ, 32'h40000010);
      get_start();
      `CHK(sv, 10'h085)
      `CHK(conv_acquire, 1'b1)
      wait_idle();
      repeat (12) @(posedge clk_sys);
      `CHK(compare_flag, flg_c[i])
    end
    xfer(1'b0, `ADST_OFS_CMP, 32'h0);
    `CHK(rd, 32'h00004001)
    // Single conversions on internal and ordinary channels
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      single_start <= 1'b1;
      single_pos <= auto_c[i];
      @(posedge clk_sys);
      single_start <= 1'b0;
      xfer(1'b0, `ADST_OFS_CNV, 32'h0);
      `CHK(rd, (i < 3) ? `ADST_AUTO_CNV : `ADST_RST_CNV)
      `CHK(conv_rate_divider, (i < 3) ? 10'h0FA : 10'h014)
      `CHK(conv_acquisition_count, (i < 3) ? 10'h07D : 10'h00A)
      xfer(1'b1, `ADST_OFS_CNV, `ADST_RST_CNV);
    end
    // Continuous run, delay 2, then restart mid-sequence
    xfer(1'b1, `ADST_OFS_SEQCFG, 32'h0028C631);
    xfer(1'b1, `ADST_OFS_SEQ, 32'h40000007);
    for (int i = 0; i < 3; i++) begin
      get_start();
      `CHK(sv[9:5], i[4:0])
    end
    t0 = t1;
    get_start();
    `CHK(sv, 10'h011)
    `CHK((t1 - t0 >= 3980 && t1 - t0 <= 4020), 1'b1)
    xfer(1'b1, `ADST_OFS_SEQ, 32'h80000007);
    get_start();
    `CHK(sv, 10'h011)
    xfer(1'b0, `ADST_OFS_SEQ, 32'h0);
    `CHK(rd, 32'h00000007)
    xfer(1'b1, `ADST_OFS_SEQCFG, 32'h0FF8C631);
    wait_idle();
    close_out();
  end
endmodule : adc_sequencer_timing_control_test
